// ===== hdl/irp_pkg.sv
// Constants, register map and types of the infrared post-processing block.
// Assumes one clock domain shared by sample source, bus and readers.
`default_nettype none
package irp_pkg;
	localparam int TEMP_W = 16;
	localparam int INT_W  = 17;
	// Register byte offsets.
	localparam logic [7:0] OFF_CTRL    = 8'h00;
	localparam logic [7:0] OFF_SURFACE_EMISSION_FACTOR   = 8'h04;
	localparam logic [7:0] OFF_TRANS   = 8'h08;
	localparam logic [7:0] OFF_SMOOTH  = 8'h0C;
	localparam logic [7:0] OFF_HOLDT   = 8'h10;
	localparam logic [7:0] OFF_THR     = 8'h14;
	localparam logic [7:0] OFF_HYST    = 8'h18;
	localparam logic [7:0] OFF_STATION = 8'h1C;
	localparam logic [7:0] OFF_PROC    = 8'h20;
	localparam logic [7:0] OFF_AVG     = 8'h24;
	localparam logic [7:0] OFF_DET     = 8'h28;
	localparam logic [7:0] OFF_BOX     = 8'h2C;
	localparam logic [7:0] OFF_STAT    = 8'h30;
	// Control register fields.
	localparam int CTRL_MODE_LSB  = 0;
	localparam int CTRL_UNIT_BIT  = 3;
	localparam int CTRL_LASER_BIT = 4;
	localparam int CTRL_BAUD_BIT  = 5;
	localparam int CTRL_HYST_BIT  = 6;
	// Factors are in thousandths; 1000 means unity.
	localparam logic [10:0] FACTOR_RST   = 11'h3E8;
	localparam logic [10:0] FACTOR_MIN   = 11'h064;
	localparam logic [10:0] FACTOR_MAX   = 11'h44C;
	localparam logic [20:0] FACTOR_UNITY = 21'h0F4240;
	// Smoothing time in milliseconds, hold time in seconds.
	localparam logic [15:0] SMOOTH_RST   = 16'h0014;
	localparam logic [6:0]  HOLD_MAX_S   = 7'h41;
	localparam logic [5:0]  STATION_MIN  = 6'h01;
	localparam logic [5:0]  STATION_MAX  = 6'h20;
	localparam logic [16:0] SAMPLE_RATE_HZ = 17'h003E8;
	localparam int STEP_SHIFT  = 3;
	localparam int DECAY_SHIFT = 8;
	// Fahrenheit conversion in tenths of a degree.
	localparam logic signed [21:0] F_OFFSET = 22'sh000140;
	localparam logic signed [21:0] F_NUM    = 22'sh000009;
	localparam logic signed [21:0] F_DEN    = 22'sh000005;
	typedef enum logic [2:0] {
		HOLD_OFF     = 3'b000,
		HOLD_PEAK    = 3'b001,
		HOLD_VALLEY  = 3'b010,
		HOLD_THRESHOLD_MAX_HOLD   = 3'b011,
		HOLD_AVALLEY = 3'b100
	} irp_mode_t;
	typedef enum logic [1:0] {
		ST_TRACK = 2'b00,
		ST_HOLD1 = 2'b01,
		ST_HOLD2 = 2'b10,
		ST_DECAY = 2'b11
	} irp_hstate_t;
endpackage
`default_nettype wire

// ===== hdl/irp_corr.sv
// Emission and transmission correction of raw samples.
// Assumes factors are already clamped to their legal range by the bus.
`timescale 1ns/1ps
`default_nettype none
module irp_corr (
	input  wire logic                             clk,
	input  wire logic                             rst_n,
	input  wire logic                             in_valid,
	input  wire logic signed [irp_pkg::TEMP_W-1:0] in_temp,
	input  wire logic        [10:0]               emission,
	input  wire logic        [10:0]               transmission,
	output logic                                  out_valid,
	output logic signed [irp_pkg::INT_W-1:0]      out_temp
);
	// Dividing by both factors raises the reading lost through a weak emitter or window.
	logic signed [41:0] num;
	logic signed [41:0] den;
	logic signed [41:0] quo;
	logic signed [41:0] lim_hi;
	logic signed [41:0] lim_lo;
	assign num    = 42'(in_temp) * $signed({21'h000000, irp_pkg::FACTOR_UNITY});
	assign den    = $signed({20'h00000, 22'(emission) * 22'(transmission)});
	assign quo    = num / den;
	assign lim_hi = 42'sh000_0000_7FFF;
	assign lim_lo = -42'sh000_0000_8000;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_valid <= 1'b0;
			out_temp  <= 17'sh00000;
		end else begin
			out_valid <= in_valid;
			if (in_valid) begin
				out_temp <= (quo > lim_hi) ? 17'(lim_hi) : (quo < lim_lo) ? 17'(lim_lo) : 17'(quo);
			end
		end
	end
endmodule // irp_corr
`default_nettype wire

// ===== hdl/irp_smooth.sv
// Exponential smoothing stage with a time constant set in milliseconds.
// Assumes one sample per millisecond, so the constant in samples is the setting.
`timescale 1ns/1ps
`default_nettype none
module irp_smooth (
	input  wire logic                             clk,
	input  wire logic                             rst_n,
	input  wire logic                             in_valid,
	input  wire logic signed [irp_pkg::INT_W-1:0] in_temp,
	input  wire logic        [15:0]               smoothing_time,
	output logic                                  out_valid,
	output logic signed [irp_pkg::INT_W-1:0]      out_temp
);
	function automatic logic [4:0] ceil_log2(input logic [15:0] t);
		logic [4:0] k;
		k = 5'h00;
		for (int i = 0; i < 16; i++) begin
			if ((17'h00001 << i) < 17'(t)) begin
				k = 5'(i + 1);
			end
		end
		return k;
	endfunction
	// The time constant is rounded up to a power of two so the update is a shift.
	logic signed [32:0] acc_q;
	logic               primed_q;
	logic signed [32:0] in_ext;
	logic signed [33:0] diff;
	logic signed [32:0] acc_d;
	logic        [4:0]  shift;
	assign in_ext = {in_temp, 16'h0000};
	assign diff   = 34'(in_ext) - 34'(acc_q);
	assign shift  = ceil_log2(smoothing_time);
	assign acc_d  = acc_q + 33'(diff >>> shift);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_q     <= 33'sh000000000;
			primed_q  <= 1'b0;
			out_valid <= 1'b0;
			out_temp  <= 17'sh00000;
		end else begin
			out_valid <= in_valid;
			if (in_valid) begin
				primed_q <= 1'b1;
				if (smoothing_time == 16'h0000 || !primed_q) begin
					acc_q    <= in_ext;
					out_temp <= in_temp;
				end else begin
					acc_q    <= acc_d;
					out_temp <= acc_d[32:16];
				end
			end
		end
	end
endmodule // irp_smooth
`default_nettype wire

// ===== hdl/irp_post.sv
// Infrared temperature post-processing: correction, smoothing, hold stage, settings.
// Assumes samples arrive in tenths of a degree Celsius on pclk, about one per millisecond.
`timescale 1ns/1ps
`default_nettype none
module irp_post (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        sample_valid,
	input  wire logic [15:0] sample_temp,
	input  wire logic [15:0] detector_temp,
	input  wire logic [15:0] controller_temp,
	input  wire logic        rs485_fitted,
	output logic      [15:0] processed_temperature,
	output logic      [15:0] smoothed_temperature,
	output logic             temperature_valid,
	output logic             aim_laser_output,
	output logic             baud_fast,
	output logic      [5:0]  station_number,
	output logic             unit_fahrenheit,
	output logic             hold_deactivated
);
	function automatic logic [10:0] clamp_factor(input logic [31:0] v);
		if (v < 32'(irp_pkg::FACTOR_MIN)) return irp_pkg::FACTOR_MIN;
		if (v > 32'(irp_pkg::FACTOR_MAX)) return irp_pkg::FACTOR_MAX;
		return v[10:0];
	endfunction
	// Celsius tenths to the reporting unit, saturated to 16 bits.
	function automatic logic [15:0] to_unit(input logic signed [16:0] c, input logic f);
		logic signed [21:0] v;
		v = f ? (22'(c) * irp_pkg::F_NUM) / irp_pkg::F_DEN + irp_pkg::F_OFFSET : 22'(c);
		if (v > 22'sh007FFF) return 16'h7FFF;
		if (v < -22'sh008000) return 16'h8000;
		return v[15:0];
	endfunction
	// Setting in the reporting unit back to Celsius tenths; a span drops the offset.
	function automatic logic signed [16:0] from_unit(input logic [15:0] u, input logic f,
	                                                 input logic span);
		logic signed [21:0] v;
		v = 22'($signed(u));
		if (f) v = ((span ? v : v - irp_pkg::F_OFFSET) * irp_pkg::F_DEN) / irp_pkg::F_NUM;
		return 17'(v);
	endfunction

	// Bus side.
	logic [2:0]  mode_q;
	logic        unit_f_q;
	logic        laser_q;
	logic        baud_q;
	logic        hyst_en_q;
	logic [10:0] surface_emission_factor_q;
	logic [10:0] trans_q;
	logic [15:0] smooth_t_q;
	logic [6:0]  hold_s_q;
	logic [15:0] thr_q;
	logic [15:0] hyst_q;
	logic [5:0]  station_q;
	logic        fit_s1_q;
	logic        fit_s2_q;
	logic [31:0] rdata_d;
	logic        hit_d;
	wire         setup   = psel & ~penable;
	wire         wr_take = psel & penable & pready & pwrite;
	wire  [31:0] wd      = pwdata;
	wire  [2:0]  wmode   = (wd[2:0] > 3'(irp_pkg::HOLD_AVALLEY)) ? 3'(irp_pkg::HOLD_OFF) : wd[2:0];
	wire  [6:0]  wholds  = (wd > 32'(irp_pkg::HOLD_MAX_S)) ? irp_pkg::HOLD_MAX_S : wd[6:0];
	wire  [5:0]  wstat   = (wd < 32'(irp_pkg::STATION_MIN)) ? irp_pkg::STATION_MIN :
	                       (wd > 32'(irp_pkg::STATION_MAX)) ? irp_pkg::STATION_MAX : wd[5:0];
	logic [15:0] proc_q;
	logic [15:0] avg_q;
	wire         peak_like = (mode_q == 3'(irp_pkg::HOLD_PEAK)) | (mode_q == 3'(irp_pkg::HOLD_VALLEY));
	wire         hold_off_t = peak_like & (hold_s_q == 7'h00);

	always_comb begin
		hit_d   = 1'b1;
		rdata_d = 32'h00000000;
		unique case (paddr)
			irp_pkg::OFF_CTRL:    rdata_d = {25'h0000000, hyst_en_q, baud_q, laser_q, unit_f_q, mode_q};
			irp_pkg::OFF_SURFACE_EMISSION_FACTOR:   rdata_d = {21'h000000, surface_emission_factor_q};
			irp_pkg::OFF_TRANS:   rdata_d = {21'h000000, trans_q};
			irp_pkg::OFF_SMOOTH:  rdata_d = {16'h0000, smooth_t_q};
			irp_pkg::OFF_HOLDT:   rdata_d = {25'h0000000, hold_s_q};
			irp_pkg::OFF_THR:     rdata_d = {16'h0000, thr_q};
			irp_pkg::OFF_HYST:    rdata_d = {16'h0000, hyst_q};
			irp_pkg::OFF_STATION: rdata_d = fit_s2_q ? {26'h0000000, station_q} : 32'h00000000;
			irp_pkg::OFF_PROC:    rdata_d = {16'h0000, proc_q};
			irp_pkg::OFF_AVG:     rdata_d = {16'h0000, avg_q};
			irp_pkg::OFF_DET:     rdata_d = {16'h0000, to_unit(17'($signed(detector_temp)), unit_f_q)};
			irp_pkg::OFF_BOX:     rdata_d = {16'h0000, to_unit(17'($signed(controller_temp)), unit_f_q)};
			irp_pkg::OFF_STAT:    rdata_d = {29'h00000000, fit_s2_q, 1'b0, hold_off_t};
			default:              hit_d   = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= setup;
			pslverr <= setup & ~hit_d;
			prdata  <= (setup & ~pwrite) ? rdata_d : 32'h00000000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fit_s1_q <= 1'b0;
			fit_s2_q <= 1'b0;
		end else begin
			fit_s1_q <= rs485_fitted;
			fit_s2_q <= fit_s1_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q     <= 3'(irp_pkg::HOLD_OFF);
			unit_f_q   <= 1'b0;
			laser_q    <= 1'b0;
			baud_q     <= 1'b0;
			hyst_en_q  <= 1'b0;
			surface_emission_factor_q    <= irp_pkg::FACTOR_RST;
			trans_q    <= irp_pkg::FACTOR_RST;
			smooth_t_q <= irp_pkg::SMOOTH_RST;
			hold_s_q   <= 7'h00;
			thr_q      <= 16'h0000;
			hyst_q     <= 16'h0000;
			station_q  <= irp_pkg::STATION_MIN;
		end else if (wr_take) begin
			unique case (paddr)
				irp_pkg::OFF_CTRL: begin
					mode_q    <= wmode;
					unit_f_q  <= wd[irp_pkg::CTRL_UNIT_BIT];
					laser_q   <= wd[irp_pkg::CTRL_LASER_BIT];
					baud_q    <= wd[irp_pkg::CTRL_BAUD_BIT];
					hyst_en_q <= wd[irp_pkg::CTRL_HYST_BIT];
				end
				irp_pkg::OFF_SURFACE_EMISSION_FACTOR:   surface_emission_factor_q    <= clamp_factor(wd);
				irp_pkg::OFF_TRANS:   trans_q    <= clamp_factor(wd);
				irp_pkg::OFF_SMOOTH:  smooth_t_q <= wd[15:0];
				irp_pkg::OFF_HOLDT:   hold_s_q   <= wholds;
				irp_pkg::OFF_THR:     thr_q      <= wd[15:0];
				irp_pkg::OFF_HYST:    hyst_q     <= wd[15:0];
				irp_pkg::OFF_STATION: if (fit_s2_q) station_q <= wstat;
				default: ;
			endcase
		end
	end

	// Data path.
	logic                      cv;
	logic signed [16:0]        ct;
	logic                      sv;
	logic signed [16:0]        st;
	irp_corr u_corr (
		.clk          (pclk),
		.rst_n        (presetn),
		.in_valid     (sample_valid),
		.in_temp      ($signed(sample_temp)),
		.emission     (surface_emission_factor_q),
		.transmission (trans_q),
		.out_valid    (cv),
		.out_temp     (ct)
	);
	irp_smooth u_smooth (
		.clk            (pclk),
		.rst_n          (presetn),
		.in_valid       (cv),
		.in_temp        (ct),
		.smoothing_time (smooth_t_q),
		.out_valid      (sv),
		.out_temp       (st)
	);

	// Minimum modes run the maximum logic on negated values.
	wire                pol_min = (mode_q == 3'(irp_pkg::HOLD_VALLEY)) |
	                              (mode_q == 3'(irp_pkg::HOLD_AVALLEY));
	wire                adv     = (mode_q == 3'(irp_pkg::HOLD_THRESHOLD_MAX_HOLD)) | (mode_q == 3'(irp_pkg::HOLD_AVALLEY));
	wire signed [16:0]  x       = pol_min ? -st : st;
	wire signed [16:0]  thr_c   = from_unit(thr_q, unit_f_q, 1'b0);
	wire signed [16:0]  thr     = pol_min ? -thr_c : thr_c;
	wire signed [16:0]  hyst    = hyst_en_q ? from_unit(hyst_q, unit_f_q, 1'b1) : 17'sh00000;
	wire         [16:0] lim     = 17'(hold_s_q * irp_pkg::SAMPLE_RATE_HZ);
	wire                inf     = (hold_s_q == irp_pkg::HOLD_MAX_S);

	irp_pkg::irp_hstate_t st_q;
	irp_pkg::irp_hstate_t st_d;
	logic signed [16:0] held_q;
	logic signed [16:0] held_d;
	logic signed [16:0] minv_q;
	logic signed [16:0] minv_d;
	logic signed [16:0] sec_q;
	logic signed [16:0] sec_d;
	logic signed [16:0] cand_q;
	logic signed [16:0] cand_d;
	logic        [16:0] cnt_q;
	logic        [16:0] cnt_d;
	logic               armed_q;
	logic               armed_d;
	logic               primed_q;
	logic        [2:0]  mode_prev_q;
	logic signed [16:0] eighth;
	logic signed [16:0] stepv;
	logic signed [16:0] decay;
	logic               armed_now;

	assign eighth    = (held_q - minv_q) >>> irp_pkg::STEP_SHIFT;
	assign stepv     = (sec_q > held_q - eighth) ? sec_q : held_q - eighth;
	assign decay     = (held_q - x) >>> irp_pkg::DECAY_SHIFT;
	assign armed_now = armed_q | (x < thr);

	always_comb begin
		st_d    = st_q;
		held_d  = held_q;
		minv_d  = minv_q;
		sec_d   = sec_q;
		cand_d  = cand_q;
		cnt_d   = cnt_q;
		armed_d = armed_q;
		if (!primed_q || !(adv || (peak_like && !hold_off_t))) begin
			st_d    = irp_pkg::ST_TRACK;
			held_d  = x;
			cand_d  = x;
			armed_d = 1'b0;
		end else if (adv) begin
			armed_d = armed_now;
			cand_d  = (x > cand_q) ? x : cand_q;
			if (x < cand_q && x <= cand_q - hyst) begin
				cand_d = x;
				if (cand_q >= held_q || armed_now) begin
					held_d  = cand_q;
					armed_d = 1'b0;
				end
			end
		end else begin
			unique case (st_q)
				irp_pkg::ST_TRACK: begin
					held_d = x;
					if (x < held_q) begin
						st_d   = irp_pkg::ST_HOLD1;
						held_d = held_q;
						minv_d = x;
						sec_d  = x;
						cnt_d  = 17'h00001;
					end
				end
				irp_pkg::ST_HOLD1: begin
					if (x >= held_q) begin
						st_d   = irp_pkg::ST_TRACK;
						held_d = x;
					end else begin
						minv_d = (x < minv_q) ? x : minv_q;
						sec_d  = (x > sec_q) ? x : sec_q;
						cnt_d  = cnt_q + 17'h00001;
						if (!inf && cnt_q >= lim) begin
							st_d   = irp_pkg::ST_HOLD2;
							held_d = stepv;
							cnt_d  = 17'h00001;
						end
					end
				end
				irp_pkg::ST_HOLD2: begin
					cnt_d = cnt_q + 17'h00001;
					if (x >= held_q) begin
						st_d   = irp_pkg::ST_TRACK;
						held_d = x;
					end else if (!inf && cnt_q >= lim) begin
						st_d = irp_pkg::ST_DECAY;
					end
				end
				irp_pkg::ST_DECAY: begin
					// A slow decay that can no longer move snaps onto the live value.
					if (x >= held_q || decay == 17'sh00000) begin
						st_d   = irp_pkg::ST_TRACK;
						held_d = x;
					end else begin
						held_d = held_q - decay;
					end
				end
			endcase
		end
	end

	wire signed [16:0] out_x = (mode_q == 3'(irp_pkg::HOLD_OFF) || hold_off_t) ? x : held_d;
	wire signed [16:0] out_c = pol_min ? -out_x : out_x;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q        <= irp_pkg::ST_TRACK;
			held_q      <= 17'sh00000;
			minv_q      <= 17'sh00000;
			sec_q       <= 17'sh00000;
			cand_q      <= 17'sh00000;
			cnt_q       <= 17'h00000;
			armed_q     <= 1'b0;
			primed_q    <= 1'b0;
			mode_prev_q <= 3'(irp_pkg::HOLD_OFF);
		end else begin
			mode_prev_q <= mode_q;
			// A mode change restarts the hold stage from the live value.
			if (mode_prev_q != mode_q) begin
				primed_q <= 1'b0;
				st_q     <= irp_pkg::ST_TRACK;
			end else if (sv) begin
				primed_q <= 1'b1;
				st_q     <= st_d;
				held_q   <= held_d;
				minv_q   <= minv_d;
				sec_q    <= sec_d;
				cand_q   <= cand_d;
				cnt_q    <= cnt_d;
				armed_q  <= armed_d;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			proc_q                <= 16'h0000;
			avg_q                 <= 16'h0000;
			processed_temperature <= 16'h0000;
			smoothed_temperature  <= 16'h0000;
			temperature_valid     <= 1'b0;
			aim_laser_output      <= 1'b0;
			baud_fast             <= 1'b0;
			station_number        <= irp_pkg::STATION_MIN;
			unit_fahrenheit       <= 1'b0;
			hold_deactivated      <= 1'b0;
		end else begin
			temperature_valid <= sv;
			if (sv) begin
				proc_q                <= to_unit(out_c, unit_f_q);
				avg_q                 <= to_unit(st, unit_f_q);
				processed_temperature <= to_unit(out_c, unit_f_q);
				smoothed_temperature  <= to_unit(st, unit_f_q);
			end
			aim_laser_output <= laser_q;
			baud_fast        <= baud_q;
			station_number   <= station_q;
			unit_fahrenheit  <= unit_f_q;
			hold_deactivated <= hold_off_t;
		end
	end
endmodule // irp_post
`default_nettype wire

// ===== tb/irp_src.sv
// Detector sample source model: one sample strobe for each request.
// Assumes requests come at least two cycles apart on pclk.
`timescale 1ns/1ps
`default_nettype none
module irp_src (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        req,
	input  wire logic [15:0] val,
	output logic             sample_valid,
	output logic      [15:0] sample_temp
);
	// Outside the strobe the data toggles, so a capture on the wrong cycle shows up.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sample_valid <= 1'b0;
			sample_temp  <= 16'h0000;
		end else begin
			sample_valid <= req;
			sample_temp  <= req ? val : ~sample_temp;
		end
	end
endmodule // irp_src
`default_nettype wire

// ===== tb/irp_post_sva.sv
// Checker of the post-processing block, bound to its top module.
// Assumes all traffic runs on pclk.
`timescale 1ns/1ps
`default_nettype none
module irp_post_sva (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        sample_valid,
	input wire logic        temperature_valid,
	input wire logic        aim_laser_output,
	input wire logic        baud_fast,
	input wire logic [5:0]  station_number
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire ctrl_wr = psel && penable && pwrite && pready && paddr == irp_pkg::OFF_CTRL;
	property p_ready; psel && !penable |=> pready; endproperty
	a_ready: assert property (p_ready) else $error("no answer after setup");
	property p_cause; pready |-> $past(psel && !penable); endproperty
	a_cause: assert property (p_cause) else $error("answer without setup");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err) else $error("error outside access");
	property p_rdata; !pready |-> prdata == 32'h00000000; endproperty
	a_rdata: assert property (p_rdata) else $error("read data outside access");
	property p_lat; sample_valid |-> ##3 temperature_valid; endproperty
	a_lat: assert property (p_lat) else $error("result latency wrong");
	property p_lat_c; temperature_valid |-> $past(sample_valid, 3); endproperty
	a_lat_c: assert property (p_lat_c) else $error("result without sample");
	property p_station; station_number >= 6'h01 && station_number <= 6'h20; endproperty
	a_station: assert property (p_station) else $error("station out of range");
	property p_laser; $changed(aim_laser_output) |-> $past(ctrl_wr) || $past(ctrl_wr, 2);
	endproperty
	a_laser: assert property (p_laser) else $error("laser moved without write");
	property p_baud; $changed(baud_fast) |-> $past(ctrl_wr) || $past(ctrl_wr, 2); endproperty
	a_baud: assert property (p_baud) else $error("baud moved without write");
endmodule // irp_post_sva
bind irp_post irp_post_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .sample_valid(sample_valid), .temperature_valid(temperature_valid),
	.aim_laser_output(aim_laser_output), .baud_fast(baud_fast),
	.station_number(station_number));
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench of the post-processing block with a sample source model.
// Assumes unity factors until the last scenarios, so bypassed samples come out unchanged.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; \
	$display("MISMATCH %0t got %0h exp %0h", $time, (a), (b)); end end
module tb;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic        req = 0, fitted = 0, pready, pslverr, sample_valid, temperature_valid;
	logic        aim_laser_output, baud_fast, unit_fahrenheit, hold_deactivated, err;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [15:0] val = 16'h0, sample_temp, processed_temperature, smoothed_temperature;
	logic [15:0] v, pk, e, r, exp_q[$], raw_q[$];
	logic [5:0]  station_number;
	int          bad_count = 0, compares = 0, cyc = 0;
	always #5 pclk = ~pclk;
	irp_src src (.pclk(pclk), .presetn(presetn), .req(req), .val(val),
		.sample_valid(sample_valid), .sample_temp(sample_temp));
	irp_post uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sample_valid(sample_valid), .sample_temp(sample_temp),
		.detector_temp(16'h0123), .controller_temp(16'h0456), .rs485_fitted(fitted),
		.processed_temperature(processed_temperature), .temperature_valid(temperature_valid),
		.smoothed_temperature(smoothed_temperature), .aim_laser_output(aim_laser_output),
		.baud_fast(baud_fast), .station_number(station_number),
		.unit_fahrenheit(unit_fahrenheit), .hold_deactivated(hold_deactivated));
	task end_sim;
		$display("Counts: %0d mismatches in %0d compares", bad_count, compares);
		if (bad_count == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		`CHK(rd, x)
	endtask
	task send(input logic [15:0] t, input logic [15:0] x, input logic [15:0] s);
		@(posedge pclk);
		req <= 1'b1;
		val <= t;
		exp_q.push_back(x);
		raw_q.push_back(s);
		@(posedge pclk);
		req <= 1'b0;
		while (exp_q.size() != 0) @(posedge pclk);
	endtask
	always @(posedge pclk) begin
		if (presetn && temperature_valid === 1'b1) begin
			if (exp_q.size() == 0) `CHK(1'b0, 1'b1)
			else begin
				// Pop once, since the compare macro reads its arguments twice.
				e = exp_q.pop_front();
				r = raw_q.pop_front();
				`CHK(processed_temperature, e)
				`CHK(smoothed_temperature, r)
			end
		end
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			end_sim;
		end
	end
	initial begin
		void'($urandom(42));
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rdc(irp_pkg::OFF_TRANS, 32'd1000);
		rdc(irp_pkg::OFF_SURFACE_EMISSION_FACTOR, 32'd1000);
		rdc(irp_pkg::OFF_SMOOTH, 32'd20);
		rdc(irp_pkg::OFF_CTRL, 32'd0);
		apb(1'b1, irp_pkg::OFF_STATION, 32'd5);
		rdc(irp_pkg::OFF_STATION, 32'd0);
		`CHK(station_number, 6'h01)
		fitted <= 1'b1;
		apb(1'b1, irp_pkg::OFF_STATION, 32'd0);
		rdc(irp_pkg::OFF_STATION, 32'd1);
		apb(1'b1, irp_pkg::OFF_STATION, 32'd40);
		rdc(irp_pkg::OFF_STATION, 32'd32);
		apb(1'b1, irp_pkg::OFF_CTRL, 32'h38);
		repeat (2) @(posedge pclk);
		`CHK({aim_laser_output, baud_fast, unit_fahrenheit}, 3'b111)
		rdc(irp_pkg::OFF_BOX, 32'(1110 * 9 / 5 + 320));
		apb(1'b1, irp_pkg::OFF_CTRL, 32'h0);
		repeat (2) @(posedge pclk);
		`CHK({aim_laser_output, baud_fast, unit_fahrenheit}, 3'b000)
		apb(1'b0, 8'h40, 32'h0);
		`CHK({err, rd}, {1'b1, 32'h0})
		rdc(irp_pkg::OFF_DET, 32'h0123);
		apb(1'b1, irp_pkg::OFF_SMOOTH, 32'h0);
		for (int i = 0; i < 6; i++) begin
			v = 16'($urandom % 4000);
			send(v, v, v);
		end
		for (int m = 0; m < 5; m++) begin
			apb(1'b1, irp_pkg::OFF_CTRL, 32'(m));
			send(v, v, v);
		end
		apb(1'b1, irp_pkg::OFF_HOLDT, 32'h0);
		apb(1'b1, irp_pkg::OFF_CTRL, 32'h1);
		repeat (2) @(posedge pclk);
		`CHK(hold_deactivated, 1'b1)
		apb(1'b1, irp_pkg::OFF_HOLDT, 32'd100);
		rdc(irp_pkg::OFF_HOLDT, 32'd65);
		`CHK(hold_deactivated, 1'b0)
		for (int m = 1; m < 3; m++) begin
			apb(1'b1, irp_pkg::OFF_CTRL, 32'(m));
			for (int i = 0; i < 6; i++) begin
				v = 16'($urandom % 4000);
				pk = (i == 0) ? v : (m == 1) ? ((v > pk) ? v : pk) : ((v < pk) ? v : pk);
				send(v, pk, v);
			end
		end
		apb(1'b1, irp_pkg::OFF_PROC, 32'h1234);
		rdc(irp_pkg::OFF_PROC, {16'h0, pk});
		// One second of hold is a thousand samples; the peak then steps down by an eighth.
		apb(1'b1, irp_pkg::OFF_HOLDT, 32'd1);
		apb(1'b1, irp_pkg::OFF_CTRL, 32'h1);
		pk = 16'($urandom % 2000) + 16'd2000;
		v = 16'($urandom % 2000);
		for (int i = 0; i < 1100; i++) begin
			send((i == 0) ? pk : v, (i <= 1000) ? pk : pk - (pk - v) / 16'd8, (i == 0) ? pk : v);
		end
		apb(1'b1, irp_pkg::OFF_SURFACE_EMISSION_FACTOR, 32'd50);
		rdc(irp_pkg::OFF_SURFACE_EMISSION_FACTOR, 32'd100);
		apb(1'b1, irp_pkg::OFF_CTRL, 32'h0);
		v = 16'($urandom % 3000);
		send(v, 16'(v * 10), 16'(v * 10));
		apb(1'b1, irp_pkg::OFF_SMOOTH, 32'd2);
		send(v + 16'd2, 16'(v * 10 + 10), 16'(v * 10 + 10));
		end_sim;
	end
endmodule // tb
`default_nettype wire
